// file: hdl/vie_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef VIE_MAP_SVH
`define VIE_MAP_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define VIE_IE_ADDR        8'ha8
`define VIE_IP_ADDR        8'hb8
`define VIE_TIMER_CONTROL_REGISTER_ADDR      8'h88
`define VIE_IE_RESET       8'h00
`define VIE_IP_RESET       7'h00
`define VIE_IP_UNUSED_RD   1'b1
// ----------------------------------------
// field positions
// ----------------------------------------
`define VIE_GLOBAL_BIT     7
`define VIE_SPI_BIT        6
`define VIE_TMR2_BIT       5
`define VIE_UART0_BIT      4
`define VIE_TMR1_BIT       3
`define VIE_EXT1_BIT       2
`define VIE_TMR0_BIT       1
`define VIE_EXT0_BIT       0
`define VIE_TIMER_CONTROL_REGISTER_EXT0_BIT  1
`define VIE_TIMER_CONTROL_REGISTER_EXT1_BIT  3
// ----------------------------------------
// sources and vectors
// ----------------------------------------
`define VIE_NUM_SRC        21
`define VIE_NUM_MAIN       7
`define VIE_ORD_EXT0       5'd0
`define VIE_ORD_TMR0       5'd1
`define VIE_ORD_EXT1       5'd2
`define VIE_ORD_TMR1       5'd3
`define VIE_ORD_SPI        5'd6
`define VIE_ORD_RESERVED   17
`define VIE_VEC_BASE       16'h0003
`define VIE_VEC_RESET      16'h0000
`define VIE_VEC_LAST       16'h00a3
`define VIE_VEC_RESERVED   16'h008b
// ----------------------------------------
// timing, in system clocks
// ----------------------------------------
`define VIE_DETECT_CYCLES  1
`define VIE_LONG_CALL_TO_HANDLER_CYCLES   5
`endif

// file: hdl/vie_pkg.sv
// shared types of the vectored interrupt enable controller
package vie_pkg;
  typedef enum logic [1:0] {
    SVC_NONE          = 2'b00,
    SVC_LOW           = 2'b01,
    SVC_HIGH          = 2'b10,
    SVC_HIGH_OVER_LOW = 2'b11
  } vie_svc_t;
  typedef logic [4:0]  vie_order_t;
  typedef logic [20:0] vie_src_t;
endpackage : vie_pkg

// file: hdl/vie_arb_if.sv
// request and grant signals between controller and arbiter
`timescale 1ns/1ps
interface vie_arb_if;
  vie_pkg::vie_src_t  req;
  vie_pkg::vie_src_t  prio;
  logic               hi_ok;
  logic               lo_ok;
  logic               valid;
  logic               level;
  vie_pkg::vie_order_t order;
  modport arb (input req, input prio, input hi_ok, input lo_ok,
               output valid, output level, output order);
  modport ctl (output req, output prio, output hi_ok, output lo_ok,
               input valid, input level, input order);
endinterface : vie_arb_if

// file: hdl/vie_arbiter.sv
// level-then-fixed-order arbiter over all sources
`timescale 1ns/1ps
`include "vie_map.svh"
module vie_arbiter (
  vie_arb_if.arb a
);
  // ----------------------------------------
  // lowest set index
  // ----------------------------------------
  function automatic logic [5:0] vie_first(input vie_pkg::vie_src_t v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `VIE_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : vie_first

  logic [5:0] hi_win;
  logic [5:0] lo_win;

  always_comb begin
    hi_win = vie_first(a.req & a.prio & {`VIE_NUM_SRC{a.hi_ok}});
    lo_win = vie_first(a.req & ~a.prio & {`VIE_NUM_SRC{a.lo_ok}});
    if (hi_win[5]) begin
      a.valid = 1'b1;
      a.level = 1'b1;
      a.order = hi_win[4:0];
    end else begin
      a.valid = lo_win[5];
      a.level = 1'b0;
      a.order = lo_win[4:0];
    end
  end
endmodule : vie_arbiter

// file: hdl/vie_ctrl.sv
// vectored interrupt enable, priority and vector controller
//
// Notes on behaviour
// - each source vectors to 0x0003 plus eight times its order, order 17 is unused, reset is 0x0000.
// - external source one vectors to 0x0013 at order 2 and both external flags clear when vectored.
// - every source but reset has its own enable bit and its own level bit.
// - the global enable, bit 7, blocks every request when low and defers to each mask when high.
// - enable bit 6 gates all serial peripheral interface requests.
// - enable bit 5 gates timer two, raised by its low or high overflow flag.
// - enable bit 4 gates the first uart, raised by receive or transmit, never cleared on vectoring.
// - enable bit 3 gates timer one overflow, vector 0x001B at order 3.
// - enable bit 2 gates the external pin one source.
// - enable bit 1 gates timer zero overflow, vector 0x000B at order 1.
// - enable bit 0 gates the external pin zero source.
// - the main enable register sits at 0xA8 on every page, bit addressable, reset to zero.
// - a high-level request preempts a low-level handler, and a high-level handler is never preempted.
// - among equal-level requests the lowest order wins.
// - requests are sampled and decoded every clock, so the request shows one clock after the flag.
// - a flag still set after the return from handler raises a new request at once.
`timescale 1ns/1ps
`include "vie_map.svh"
module vie_ctrl (
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_WE,
  input  wire logic        SFR_RE,
  output logic      [7:0]  SFR_RDATA,
  input  wire logic [7:0]  SFR_BIT_ADDR,
  input  wire logic        SFR_BIT_WDATA,
  input  wire logic        SFR_BIT_WE,
  input  wire logic        EXT_IRQ_PIN_ZERO_N,
  input  wire logic        EXT_IRQ_PIN_ONE_N,
  input  wire logic        TIMER_ZERO_OVERFLOW_FLAG,
  input  wire logic        TIMER_ONE_OVERFLOW_FLAG,
  input  wire logic        UART_ZERO_RECEIVE_FLAG,
  input  wire logic        UART_ZERO_TRANSMIT_FLAG,
  input  wire logic        TIMER_TWO_LOW_OVERFLOW_FLAG,
  input  wire logic        TIMER_TWO_HIGH_OVERFLOW_FLAG,
  input  wire logic [3:0]  SPI_FLAGS,
  input  wire logic [20:7] EXT_PENDING,
  input  wire logic [20:7] EXT_ENABLE,
  input  wire logic [20:7] EXT_PRIORITY,
  input  wire logic        CORE_ACK,
  input  wire logic        CORE_RETURN_FROM_HANDLER,
  output logic             IRQ_REQ,
  output logic      [15:0] IRQ_VECTOR,
  output logic             IRQ_LEVEL,
  output logic      [20:0] VECTOR_TAKEN,
  output logic             EXT_ZERO_PENDING_FLAG,
  output logic             EXT_ONE_PENDING_FLAG
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] vie_vector(input vie_pkg::vie_order_t ord);
    return `VIE_VEC_BASE + {8'h00, ord, 3'b000};
  endfunction : vie_vector

  function automatic logic bit_hit(input logic [7:0] badr, input logic [7:0] base);
    return badr[7:3] == base[7:3];
  endfunction : bit_hit

  logic [7:0]          ie;
  logic [6:0]          ip;
  logic [2:0]          pin0_sync;
  logic [2:0]          pin1_sync;
  logic                ext0_edge;
  logic                ext1_edge;
  logic                ext_zero_pending_flag;
  logic                ext_one_pending_flag;
  vie_pkg::vie_src_t   pend;
  vie_pkg::vie_src_t   en;
  vie_pkg::vie_src_t   prio;
  vie_pkg::vie_src_t   req_vec;
  vie_pkg::vie_src_t   lo_req_vec;
  vie_pkg::vie_svc_t   svc_state;
  vie_pkg::vie_svc_t   next_svc_state;
  vie_pkg::vie_order_t irq_order;
  logic                lo_req_any;
  vie_arb_if           arb ();

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // byte write and bit write in one cycle: bit write wins for its bit
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ie <= `VIE_IE_RESET;
    end else begin
      if (SFR_WE && SFR_ADDR == `VIE_IE_ADDR) begin
        ie <= SFR_WDATA;
      end
      if (SFR_BIT_WE && bit_hit(SFR_BIT_ADDR, `VIE_IE_ADDR)) begin
        ie[SFR_BIT_ADDR[2:0]] <= SFR_BIT_WDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ip <= `VIE_IP_RESET;
    end else begin
      if (SFR_WE && SFR_ADDR == `VIE_IP_ADDR) begin
        ip <= SFR_WDATA[6:0];
      end
      if (SFR_BIT_WE && bit_hit(SFR_BIT_ADDR, `VIE_IP_ADDR) && SFR_BIT_ADDR[2:0] != 3'h7) begin
        ip[SFR_BIT_ADDR[2:0]] <= SFR_BIT_WDATA;
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RE) begin
      case (SFR_ADDR)
        `VIE_IE_ADDR:   SFR_RDATA <= ie;
        `VIE_IP_ADDR:   SFR_RDATA <= {`VIE_IP_UNUSED_RD, ip};
        `VIE_TIMER_CONTROL_REGISTER_ADDR: SFR_RDATA <= {4'h0, ext_one_pending_flag, 1'b0, ext_zero_pending_flag, 1'b0};
        default:        SFR_RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  // stage 0 only feeds stage 1; edges are seen on stages 1 and 2
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pin0_sync <= 3'h7;
      pin1_sync <= 3'h7;
    end else begin
      pin0_sync <= {pin0_sync[1:0], EXT_IRQ_PIN_ZERO_N};
      pin1_sync <= {pin1_sync[1:0], EXT_IRQ_PIN_ONE_N};
    end
  end

  assign ext0_edge = pin0_sync[2] & ~pin0_sync[1];
  assign ext1_edge = pin1_sync[2] & ~pin1_sync[1];

  // set wins over vectoring clear and software clear
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ext_zero_pending_flag <= 1'b0;
    end else if (ext0_edge) begin
      ext_zero_pending_flag <= 1'b1;
    end else if (CORE_ACK && IRQ_REQ && irq_order == `VIE_ORD_EXT0) begin
      ext_zero_pending_flag <= 1'b0;
    end else if (SFR_WE && SFR_ADDR == `VIE_TIMER_CONTROL_REGISTER_ADDR) begin
      ext_zero_pending_flag <= SFR_WDATA[`VIE_TIMER_CONTROL_REGISTER_EXT0_BIT];
    end else if (SFR_BIT_WE && SFR_BIT_ADDR == `VIE_TIMER_CONTROL_REGISTER_ADDR + 8'(`VIE_TIMER_CONTROL_REGISTER_EXT0_BIT)) begin
      ext_zero_pending_flag <= SFR_BIT_WDATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ext_one_pending_flag <= 1'b0;
    end else if (ext1_edge) begin
      ext_one_pending_flag <= 1'b1;
    end else if (CORE_ACK && IRQ_REQ && irq_order == `VIE_ORD_EXT1) begin
      ext_one_pending_flag <= 1'b0;
    end else if (SFR_WE && SFR_ADDR == `VIE_TIMER_CONTROL_REGISTER_ADDR) begin
      ext_one_pending_flag <= SFR_WDATA[`VIE_TIMER_CONTROL_REGISTER_EXT1_BIT];
    end else if (SFR_BIT_WE && SFR_BIT_ADDR == `VIE_TIMER_CONTROL_REGISTER_ADDR + 8'(`VIE_TIMER_CONTROL_REGISTER_EXT1_BIT)) begin
      ext_one_pending_flag <= SFR_BIT_WDATA;
    end
  end

  assign EXT_ZERO_PENDING_FLAG = ext_zero_pending_flag;
  assign EXT_ONE_PENDING_FLAG  = ext_one_pending_flag;

  // ----------------------------------------
  // request forming
  // ----------------------------------------
  always_comb begin
    pend = {EXT_PENDING,
            |SPI_FLAGS,
            TIMER_TWO_LOW_OVERFLOW_FLAG | TIMER_TWO_HIGH_OVERFLOW_FLAG,
            UART_ZERO_RECEIVE_FLAG | UART_ZERO_TRANSMIT_FLAG,
            TIMER_ONE_OVERFLOW_FLAG,
            ext_one_pending_flag,
            TIMER_ZERO_OVERFLOW_FLAG,
            ext_zero_pending_flag};
    en   = {EXT_ENABLE, ie[`VIE_NUM_MAIN-1:0]};
    prio = {EXT_PRIORITY, ip};
    pend[`VIE_ORD_RESERVED] = 1'b0;
    req_vec = pend & en & {`VIE_NUM_SRC{ie[`VIE_GLOBAL_BIT]}};
  end

  assign lo_req_vec = req_vec & ~prio;
  assign lo_req_any = |lo_req_vec;

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  assign arb.req   = req_vec;
  assign arb.prio  = prio;
  assign arb.hi_ok = svc_state == vie_pkg::SVC_NONE || svc_state == vie_pkg::SVC_LOW;
  assign arb.lo_ok = svc_state == vie_pkg::SVC_NONE;

  vie_arbiter u_arb (
    .a (arb.arb)
  );

  // decoded every clock; winner not held, request dropped for the clock after an ack
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      IRQ_REQ    <= 1'b0;
      IRQ_LEVEL  <= 1'b0;
      IRQ_VECTOR <= `VIE_VEC_RESET;
      irq_order  <= 5'h00;
    end else begin
      IRQ_REQ    <= arb.valid & ~CORE_ACK;
      IRQ_LEVEL  <= arb.level;
      IRQ_VECTOR <= arb.valid ? vie_vector(arb.order) : `VIE_VEC_RESET;
      irq_order  <= arb.order;
    end
  end

  // ----------------------------------------
  // service nesting
  // ----------------------------------------
  always_comb begin
    next_svc_state = svc_state;
    case (svc_state)
      vie_pkg::SVC_NONE: begin
        if (CORE_ACK && IRQ_REQ) begin
          next_svc_state = IRQ_LEVEL ? vie_pkg::SVC_HIGH : vie_pkg::SVC_LOW;
        end
      end
      vie_pkg::SVC_LOW: begin
        if (CORE_ACK && IRQ_REQ && IRQ_LEVEL) begin
          next_svc_state = vie_pkg::SVC_HIGH_OVER_LOW;
        end else if (CORE_RETURN_FROM_HANDLER) begin
          next_svc_state = vie_pkg::SVC_NONE;
        end
      end
      vie_pkg::SVC_HIGH: begin
        if (CORE_RETURN_FROM_HANDLER) begin
          next_svc_state = vie_pkg::SVC_NONE;
        end
      end
      vie_pkg::SVC_HIGH_OVER_LOW: begin
        if (CORE_RETURN_FROM_HANDLER) begin
          next_svc_state = vie_pkg::SVC_LOW;
        end
      end
      default: next_svc_state = vie_pkg::SVC_NONE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      svc_state <= vie_pkg::SVC_NONE;
    end else begin
      svc_state <= next_svc_state;
    end
  end

  // peripheral side clears its own flag from this pulse where it wants to
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      VECTOR_TAKEN <= '0;
    end else begin
      VECTOR_TAKEN <= (CORE_ACK && IRQ_REQ) ? vie_pkg::vie_src_t'(1) << irq_order : '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_vec_form;
    @(posedge REF_CLK) disable iff (SRST)
      IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR != `VIE_VEC_RESERVED && IRQ_VECTOR <= `VIE_VEC_LAST;
  endproperty
  a_vec_form: assert property (p_vec_form) else $error("bad vector");
  property p_ext1_clear;
    @(posedge REF_CLK) disable iff (SRST)
      CORE_ACK && IRQ_REQ && irq_order == `VIE_ORD_EXT1 && !ext1_edge |=> !ext_one_pending_flag;
  endproperty
  a_ext1_clear: assert property (p_ext1_clear) else $error("ext one flag kept");
  property p_global_off;
    @(posedge REF_CLK) disable iff (SRST)
      !ie[`VIE_GLOBAL_BIT] |=> !IRQ_REQ;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request with global off");
  property p_spi_mask;
    @(posedge REF_CLK) disable iff (SRST)
      !ie[`VIE_SPI_BIT] |=> !(IRQ_REQ && irq_order == `VIE_ORD_SPI);
  endproperty
  a_spi_mask: assert property (p_spi_mask) else $error("masked spi taken");
  property p_tmr1_vec;
    @(posedge REF_CLK) disable iff (SRST)
      IRQ_REQ && irq_order == `VIE_ORD_TMR1 |-> IRQ_VECTOR == 16'h001b && $past(ie[`VIE_TMR1_BIT]);
  endproperty
  a_tmr1_vec: assert property (p_tmr1_vec) else $error("timer one vector");
  property p_high_no_preempt;
    @(posedge REF_CLK) disable iff (SRST)
      svc_state == vie_pkg::SVC_HIGH || svc_state == vie_pkg::SVC_HIGH_OVER_LOW |=> !IRQ_REQ;
  endproperty
  a_high_no_preempt: assert property (p_high_no_preempt) else $error("high handler preempted");
  property p_low_order;
    @(posedge REF_CLK) disable iff (SRST)
      IRQ_REQ && !IRQ_LEVEL |-> ($past(lo_req_vec) & ((vie_pkg::vie_src_t'(1) << irq_order) - 1'b1)) == '0;
  endproperty
  a_low_order: assert property (p_low_order) else $error("lower order skipped");
  property p_detect;
    @(posedge REF_CLK) disable iff (SRST)
      req_vec != '0 && svc_state == vie_pkg::SVC_NONE && !CORE_ACK |=> IRQ_REQ;
  endproperty
  a_detect: assert property (p_detect) else $error("request late");
  property p_reenter;
    @(posedge REF_CLK) disable iff (SRST)
      CORE_RETURN_FROM_HANDLER && svc_state == vie_pkg::SVC_LOW && lo_req_any ##1 (lo_req_any && !CORE_ACK) |=> IRQ_REQ;
  endproperty
  a_reenter: assert property (p_reenter) else $error("no request after return");
  property p_flag_masked;
    @(posedge REF_CLK) disable iff (SRST)
      ext0_edge |=> ext_zero_pending_flag;
  endproperty
  a_flag_masked: assert property (p_flag_masked) else $error("ext zero flag lost");
  property p_ie_reset;
    @(posedge REF_CLK)
      SRST |=> ie == 8'h00;
  endproperty
  a_ie_reset: assert property (p_ie_reset) else $error("enable not reset");
endmodule : vie_ctrl

// file: tb/vie_core_model.sv
// processor core stand-in: takes vectors and returns on command
`timescale 1ns/1ps
module vie_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        auto_ack,
  input  wire logic [3:0]  ack_dly,
  input  wire logic        ret_cmd,
  output logic             ack,
  output logic             return_from_handler,
  output logic      [15:0] vec_seen,
  output logic      [1:0]  depth
);
  logic [3:0] wait_cnt;
  // ----------------------------------------
  // call and return
  // ----------------------------------------
  // ack only while a request stands; one return per taken call
  always_ff @(posedge clk) begin
    ack  <= 1'b0;
    return_from_handler <= 1'b0;
    if (rst) begin
      wait_cnt <= 4'h0;
      depth    <= 2'h0;
      vec_seen <= 16'h0000;
    end else if (ret_cmd && depth != 2'h0) begin
      return_from_handler  <= 1'b1;
      depth <= depth - 2'h1;
    end else if (auto_ack && irq_req && !ack) begin
      if (wait_cnt == ack_dly) begin
        ack      <= 1'b1;
        vec_seen <= irq_vector;
        depth    <= depth + 2'h1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : vie_core_model

// file: tb/vie_ctrl_test.sv
// self-checking bench of the interrupt controller through its register port
`timescale 1ns/1ps
module vie_ctrl_test;
  logic        REF_CLK = 1'b0;
  logic        SRST    = 1'b1;
  logic [7:0]  SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_BIT_ADDR = 8'h00, SFR_RDATA;
  logic        SFR_WE = 1'b0, SFR_RE = 1'b0, SFR_BIT_WDATA = 1'b0, SFR_BIT_WE = 1'b0;
  logic [11:0] src_v = 12'h000;
  logic [13:0] ext_pend = 14'h0000, ext_en = 14'h0000, ext_pri = 14'h0000;
  logic        CORE_ACK, CORE_RETURN_FROM_HANDLER, IRQ_REQ, IRQ_LEVEL, EXT_ZERO_PENDING_FLAG, EXT_ONE_PENDING_FLAG;
  logic [15:0] IRQ_VECTOR, vec_seen;
  logic [20:0] VECTOR_TAKEN, t;
  logic [1:0]  depth;
  logic        auto_ack = 1'b0, ret_cmd = 1'b0;
  logic [3:0]  ack_dly = 4'h0;
  int          error_cnt = 0, cmp_count = 0;

  always #2 REF_CLK = ~REF_CLK;

  vie_ctrl dut_u (
    .REF_CLK(REF_CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
    .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .SFR_BIT_ADDR(SFR_BIT_ADDR), .SFR_BIT_WDATA(SFR_BIT_WDATA),
    .SFR_BIT_WE(SFR_BIT_WE), .EXT_IRQ_PIN_ZERO_N(~src_v[0]), .EXT_IRQ_PIN_ONE_N(~src_v[2]),
    .TIMER_ZERO_OVERFLOW_FLAG(src_v[1]), .TIMER_ONE_OVERFLOW_FLAG(src_v[3]),
    .UART_ZERO_RECEIVE_FLAG(src_v[4]), .UART_ZERO_TRANSMIT_FLAG(src_v[5]),
    .TIMER_TWO_LOW_OVERFLOW_FLAG(src_v[6]), .TIMER_TWO_HIGH_OVERFLOW_FLAG(src_v[7]),
    .SPI_FLAGS(src_v[11:8]), .EXT_PENDING(ext_pend), .EXT_ENABLE(ext_en), .EXT_PRIORITY(ext_pri),
    .CORE_ACK(CORE_ACK), .CORE_RETURN_FROM_HANDLER(CORE_RETURN_FROM_HANDLER), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
    .IRQ_LEVEL(IRQ_LEVEL), .VECTOR_TAKEN(VECTOR_TAKEN), .EXT_ZERO_PENDING_FLAG(EXT_ZERO_PENDING_FLAG),
    .EXT_ONE_PENDING_FLAG(EXT_ONE_PENDING_FLAG)
  );

  vie_core_model core_u (
    .clk(REF_CLK), .rst(SRST), .irq_req(IRQ_REQ), .irq_vector(IRQ_VECTOR), .auto_ack(auto_ack),
    .ack_dly(ack_dly), .ret_cmd(ret_cmd), .ack(CORE_ACK), .return_from_handler(CORE_RETURN_FROM_HANDLER), .vec_seen(vec_seen),
    .depth(depth)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // every task that sets a strobe first steps past an edge so no strobe is set twice in one time step
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick

  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    SFR_ADDR  = a;
    SFR_WDATA = d;
    SFR_WE    = 1'b1;
    tick(1);
    SFR_WE = 1'b0;
  endtask : wr

  task automatic bw(input logic [7:0] a, input logic v);
    tick(1);
    SFR_BIT_ADDR  = a;
    SFR_BIT_WDATA = v;
    SFR_BIT_WE    = 1'b1;
    tick(1);
    SFR_BIT_WE = 1'b0;
  endtask : bw

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    SFR_ADDR = a;
    SFR_RE   = 1'b1;
    tick(1);
    SFR_RE = 1'b0;
    chk(SFR_RDATA, exp);
  endtask : rdc

  // polls the one-cycle taken pulse; a hang leaves zero, which fails the compare
  task automatic wait_taken(output logic [20:0] v);
    v = 21'h0;
    for (int k = 0; k < 24 && v == 21'h0; k++) begin
      tick(1);
      v = VECTOR_TAKEN;
    end
  endtask : wait_taken

  task automatic ret;
    tick(1);
    ret_cmd = 1'b1;
    tick(1);
    ret_cmd = 1'b0;
  endtask : ret

  function automatic int ord(input int i);
    return (i < 4) ? i : (i < 6) ? 4 : (i < 8) ? 5 : 6;
  endfunction : ord

  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge REF_CLK);
    #1;
    SRST = 1'b0;
    rdc(8'ha8, 8'h00);
    rdc(8'hb8, 8'h80);
    chk({IRQ_REQ, IRQ_VECTOR}, 21'h0);
    wr(8'ha8, 8'h81);
    rdc(8'ha8, 8'h81);
    bw(8'ha9, 1'b1);
    bw(8'haf, 1'b0);
    rdc(8'ha8, 8'h03);
    wr(8'h55, 8'hff);
    rdc(8'h55, 8'h00);
    rdc(8'ha8, 8'h03);
    // every main source: masked, enabled without global, enabled, masked again
    for (int i = 0; i < 12; i++) begin
      wr(8'ha8, 8'h00);
      src_v[i] = 1'b1;
      tick(5);
      chk(IRQ_REQ, 1'b0);
      chk({EXT_ONE_PENDING_FLAG, EXT_ZERO_PENDING_FLAG}, {i == 2, i == 0});
      wr(8'ha8, 8'h01 << ord(i));
      tick(2);
      chk(IRQ_REQ, 1'b0);
      wr(8'ha8, 8'h80 | (8'h01 << ord(i)));
      tick(2);
      chk(IRQ_REQ, 1'b1);
      chk(IRQ_VECTOR, 16'h0003 + 16'(ord(i)) * 16'h0008);
      wr(8'ha8, 8'h80);
      tick(2);
      chk(IRQ_REQ, 1'b0);
      src_v[i] = 1'b0;
      wr(8'h88, 8'h00);
    end
    bw(8'h8b, 1'b1);
    rdc(8'h88, 8'h08);
    bw(8'h8b, 1'b0);
    rdc(8'h88, 8'h00);
    // latency, fixed order, level
    wr(8'ha8, 8'h8a);
    src_v[1] = 1'b1;
    chk(IRQ_REQ, 1'b0);
    tick(1);
    chk(IRQ_REQ, 1'b1);
    src_v[3] = 1'b1;
    tick(2);
    chk(IRQ_VECTOR, 16'h000b);
    wr(8'hb8, 8'h08);
    tick(2);
    chk({IRQ_LEVEL, IRQ_VECTOR}, 21'h1001b);
    src_v[3] = 1'b0;
    src_v[1] = 1'b0;
    ext_pend = 14'h3fff;
    ext_en = 14'h0400;
    tick(3);
    chk(IRQ_REQ, 1'b0);
    ext_en = 14'h2400;
    tick(2);
    chk(IRQ_VECTOR, 16'h00a3);
    src_v[1] = 1'b1;
    tick(2);
    chk(IRQ_VECTOR, 16'h000b);
    ext_pri = 14'h2000;
    tick(2);
    chk({IRQ_LEVEL, IRQ_VECTOR}, 21'h100a3);
    src_v[1] = 1'b0;
    ext_pend = 14'h0000;
    ext_en = 14'h0000;
    ext_pri = 14'h0000;
    wr(8'hb8, 8'h00);
    // vectoring with a slow core: hardware clear of the pin flag
    auto_ack = 1'b1;
    ack_dly = 4'h3;
    wr(8'ha8, 8'h84);
    src_v[2] = 1'b1;
    wait_taken(t);
    chk(t, 21'h4);
    chk({EXT_ONE_PENDING_FLAG, vec_seen}, 21'h0013);
    src_v[2] = 1'b0;
    ret();
    ack_dly = 4'h0;
    // uart flags stay set, so the return re-enters at once
    wr(8'ha8, 8'h90);
    src_v[4] = 1'b1;
    wait_taken(t);
    chk(t, 21'h10);
    tick(3);
    chk({IRQ_REQ, vec_seen}, 21'h0023);
    ret();
    wait_taken(t);
    chk(t, 21'h10);
    src_v[4] = 1'b0;
    ret();
    // nesting: high preempts low, nothing preempts high
    bw(8'hbb, 1'b1);
    wr(8'ha8, 8'h9a);
    src_v[1] = 1'b1;
    wait_taken(t);
    chk(t, 21'h2);
    src_v[1] = 1'b0;
    src_v[3] = 1'b1;
    wait_taken(t);
    chk(t, 21'h8);
    chk(depth, 2'h2);
    src_v[3] = 1'b0;
    wr(8'hb8, 8'h18);
    src_v[4] = 1'b1;
    tick(4);
    chk(IRQ_REQ, 1'b0);
    ret();
    wait_taken(t);
    chk(t, 21'h10);
    src_v[4] = 1'b0;
    ret();
    ret();
    tick(2);
    chk({IRQ_REQ, depth}, 21'h0);
    SRST = 1'b1;
    tick(3);
    SRST = 1'b0;
    rdc(8'ha8, 8'h00);
    chk({IRQ_REQ, IRQ_VECTOR}, 21'h0);
    end_sim();
  end
endmodule : vie_ctrl_test
